/* File: scps_pkg.sv */
// Package for the switching clock, phase and soft-start block.
// Assumes a 20 MHz system clock and pin-level strap codes from an ADC front end.
package scps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CLK_PERIOD_NS   = 1000000000 / CLK_HZ;
  // Sync input must rise within this time or the follower falls back
  localparam int unsigned SYNC_LOSS_US    = 20;
  localparam int unsigned SYNC_LOSS_CYC   = (SYNC_LOSS_US * 1000) / CLK_PERIOD_NS;
  // Switching period counts per strap code: clk / f, rounded down
  localparam logic [7:0]  PER_571K        = 8'(CLK_HZ / 571000);
  localparam logic [7:0]  PER_615K        = 8'(CLK_HZ / 615000);
  localparam logic [7:0]  PER_727K        = 8'(CLK_HZ / 727000);
  localparam logic [7:0]  PER_800K        = 8'(CLK_HZ / 800000);
  localparam logic [7:0]  PER_DEFAULT     = PER_615K;

  ////////////////////////////////////////////////////////////////////////////
  // Strap codes for the frequency strap
  localparam logic [1:0]  FSTRAP_28K7     = 2'h0;
  localparam logic [1:0]  FSTRAP_31K6     = 2'h1;
  localparam logic [1:0]  FSTRAP_34K8     = 2'h2;
  localparam logic [1:0]  FSTRAP_38K3     = 2'h3;

  // Option strap codes, one per resistor value or pin level
  localparam logic [3:0]  OPT_10K         = 4'h0;
  localparam logic [3:0]  OPT_11K         = 4'h1;
  localparam logic [3:0]  OPT_17K8        = 4'h2;
  localparam logic [3:0]  OPT_31K6        = 4'h3;
  localparam logic [3:0]  OPT_56K2        = 4'h4;
  localparam logic [3:0]  OPT_61K9        = 4'h5;
  localparam logic [3:0]  OPT_90K9        = 4'h6;
  localparam logic [3:0]  OPT_100K        = 4'h7;
  localparam logic [3:0]  OPT_LOW         = 4'h8;
  localparam logic [3:0]  OPT_OPEN        = 4'h9;
  localparam logic [3:0]  OPT_HIGH        = 4'hA;

  // Overcurrent limits in amperes and droop in units of 0.1 mV/A
  localparam logic [5:0]  OC_20A          = 6'h14;
  localparam logic [5:0]  OC_25A          = 6'h19;
  localparam logic [5:0]  OC_35A          = 6'h23;
  localparam logic [1:0]  DROOP_0         = 2'h0;
  localparam logic [1:0]  DROOP_0P2       = 2'h2;

  // Power good thresholds as fractions of 1024 of the target reference
  localparam logic [9:0]  PG_ON_FRAC      = 10'h39A;  // 90 percent
  localparam logic [9:0]  PG_OFF_FRAC     = 10'h366;  // 85 percent

  // Sequencing modes
  localparam logic [1:0]  SEQ_TIME        = 2'h0;
  localparam logic [1:0]  SEQ_EVENT       = 2'h1;
  localparam logic [1:0]  SEQ_GROUP       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SCPS_TOPO_DUAL   = 2'h0,
    SCPS_TOPO_SINGLE = 2'h1,
    SCPS_TOPO_4MST   = 2'h2,
    SCPS_TOPO_4SLV   = 2'h3
  } scps_topo_e;

  typedef struct packed {
    logic [5:0]  oc_page0;
    logic [5:0]  oc_page1;
    scps_topo_e  topo;
    logic [1:0]  droop;
  } scps_opt_s;

  typedef struct packed {
    logic        sync_out_en;   // Pin drives the shared line
    logic        use_ext_clk;   // Follow the line instead of the internal clock
  } scps_syncfg_s;

  typedef struct packed {
    logic [15:0] on_wait;       // Turn-on wait in ticks
    logic [15:0] on_ramp;       // Turn-on ramp time in ticks
    logic [15:0] off_wait;      // Turn-off wait in ticks
    logic [15:0] off_ramp;      // Turn-off ramp time in ticks
    logic        soft_stop_en;
  } scps_ramp_s;

  typedef enum logic [2:0] {
    SCPS_OFF      = 3'b000,
    SCPS_ON_WAIT  = 3'b001,
    SCPS_RISE     = 3'b011,
    SCPS_REG      = 3'b010,
    SCPS_OFF_WAIT = 3'b110,
    SCPS_FALL     = 3'b111
  } scps_ramp_e;

endpackage

/* File: scps_opt_decode.sv */
// Option strap decoder: turns a strap code into limits, topology and droop.
// Assumes the strap code is captured once after reset by the caller.
`timescale 1ns/1ps
module scps_opt_decode (
  input  wire logic [3:0]          code,
  output scps_pkg::scps_opt_s      opt
);

  // Table lookup; unknown codes fall back to the open-pin setting
  always_comb begin
    opt = '{scps_pkg::OC_20A, scps_pkg::OC_20A, scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
    unique case (code)
      scps_pkg::OPT_10K:  opt = '{scps_pkg::OC_25A, scps_pkg::OC_25A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      scps_pkg::OPT_11K:  opt = '{scps_pkg::OC_35A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      scps_pkg::OPT_17K8: opt = '{scps_pkg::OC_35A, scps_pkg::OC_25A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      scps_pkg::OPT_31K6: opt = '{scps_pkg::OC_25A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      scps_pkg::OPT_56K2: opt = '{scps_pkg::OC_25A, scps_pkg::OC_25A,
                                  scps_pkg::SCPS_TOPO_SINGLE, scps_pkg::DROOP_0};
      scps_pkg::OPT_61K9: opt = '{scps_pkg::OC_35A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_SINGLE, scps_pkg::DROOP_0};
      scps_pkg::OPT_90K9: opt = '{scps_pkg::OC_35A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_4MST, scps_pkg::DROOP_0P2};
      scps_pkg::OPT_100K: opt = '{scps_pkg::OC_35A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_4SLV, scps_pkg::DROOP_0P2};
      scps_pkg::OPT_LOW:  opt = '{scps_pkg::OC_20A, scps_pkg::OC_20A,
                                  scps_pkg::SCPS_TOPO_SINGLE, scps_pkg::DROOP_0};
      scps_pkg::OPT_OPEN: opt = '{scps_pkg::OC_20A, scps_pkg::OC_20A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      scps_pkg::OPT_HIGH: opt = '{scps_pkg::OC_35A, scps_pkg::OC_35A,
                                  scps_pkg::SCPS_TOPO_DUAL, scps_pkg::DROOP_0};
      default: ;
    endcase
  end

endmodule // scps_opt_decode

/* File: scps_ramp.sv */
// Soft-start and soft-stop sequencer driving a 16-bit output reference.
// Assumes one tick per clock while ce is high; times are in ticks.
`timescale 1ns/1ps
module scps_ramp (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                enable,
  input  wire logic [15:0]         target,
  input  scps_pkg::scps_ramp_s     cfg,
  output logic [15:0]              vref,
  output logic                     ramping_up
);

  typedef struct packed {
    scps_pkg::scps_ramp_e st;
    logic [15:0]          cnt;
    logic [31:0]          acc;   // target*elapsed, kept as a running sum
    logic [15:0]          vref;
  } scps_rst_s;

  scps_rst_s s_q;
  scps_rst_s s_d;

  // Next state; ramp uses vref = target*elapsed/time via running sum
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      scps_pkg::SCPS_OFF: begin
        s_d.vref = 16'h0000;
        if (enable) begin
          s_d.st  = scps_pkg::SCPS_ON_WAIT;
          s_d.cnt = 16'h0000;
        end
      end
      scps_pkg::SCPS_ON_WAIT: begin
        if (!enable) begin
          s_d.st = scps_pkg::SCPS_OFF;
        end else if (s_q.cnt >= cfg.on_wait) begin
          s_d.st  = scps_pkg::SCPS_RISE;
          s_d.cnt = 16'h0000;
          s_d.acc = 32'h0000_0000;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
      scps_pkg::SCPS_RISE: begin
        if (!enable) begin
          s_d.st  = cfg.soft_stop_en ? scps_pkg::SCPS_OFF_WAIT : scps_pkg::SCPS_OFF;
          s_d.cnt = 16'h0000;
          if (!cfg.soft_stop_en) s_d.vref = 16'h0000;
        end else if (s_q.cnt >= cfg.on_ramp) begin
          s_d.st   = scps_pkg::SCPS_REG;
          s_d.vref = target;
        end else begin
          // Linear step each tick, lands on target at the last tick
          s_d.cnt  = s_q.cnt + 16'h0001;
          s_d.acc  = s_q.acc + {16'h0000, target};
          s_d.vref = 16'(s_d.acc / {16'h0000, cfg.on_ramp});
        end
      end
      scps_pkg::SCPS_REG: begin
        s_d.vref = target;
        if (!enable) begin
          s_d.cnt = 16'h0000;
          if (cfg.soft_stop_en) begin
            s_d.st = scps_pkg::SCPS_OFF_WAIT;
          end else begin
            // Hard stop: regulation ends at once
            s_d.st   = scps_pkg::SCPS_OFF;
            s_d.vref = 16'h0000;
          end
        end
      end
      scps_pkg::SCPS_OFF_WAIT: begin
        if (s_q.cnt >= cfg.off_wait) begin
          s_d.st  = scps_pkg::SCPS_FALL;
          s_d.cnt = 16'h0000;
          s_d.acc = {16'h0000, s_q.vref} * {16'h0000, cfg.off_ramp};
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
      scps_pkg::SCPS_FALL: begin
        if (s_q.cnt >= cfg.off_ramp || s_q.acc < {16'h0000, s_q.vref}) begin
          s_d.st   = scps_pkg::SCPS_OFF;
          s_d.vref = 16'h0000;
        end else begin
          s_d.cnt  = s_q.cnt + 16'h0001;
          s_d.acc  = s_q.acc - {16'h0000, target};
          s_d.vref = 16'(s_d.acc / {16'h0000, cfg.off_ramp});
        end
      end
      default: s_d.st = scps_pkg::SCPS_OFF;
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{scps_pkg::SCPS_OFF, 16'h0000, 32'h0000_0000, 16'h0000};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign vref       = s_q.vref;
  assign ramping_up = (s_q.st == scps_pkg::SCPS_ON_WAIT) || (s_q.st == scps_pkg::SCPS_RISE);

endmodule // scps_ramp

/* File: scps_top.sv */
// Switching clock, phase offset, option strap and soft-start control.
// Assumes strap codes are stable pins, sync and enable pins are asynchronous,
// and configuration words come from a command decoder on the same clock.
`timescale 1ns/1ps
module scps_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Straps, sampled once after reset
  input  wire logic [1:0]           freq_strap_code,
  input  wire logic [3:0]           option_strap_resistor,
  input  wire logic [6:0]           bus_address,
  // Frequency command
  input  wire logic                 freq_cmd_wr,
  input  wire logic [7:0]           freq_cmd_period,
  input  wire logic                 two_phase,
  // Global user configuration
  input  scps_pkg::scps_syncfg_s    sync_cfg,
  // Phase command
  input  wire logic                 phase_cmd_wr,
  input  wire logic [3:0]           phase_cmd_index,
  input  wire logic [3:0]           phase_cmd_count,
  // Ramp configuration and enable
  input  scps_pkg::scps_ramp_s      ramp_cfg,
  input  wire logic [15:0]          vout_target,
  input  wire logic                 enable_pin,
  input  wire logic [1:0]           seq_mode,
  input  wire logic                 group_wire_bus_prev_good,
  // Sync pin, three signals
  input  wire logic                 sync_in,
  output logic                      sync_out,
  output logic                      sync_oe_n,
  // Results
  output logic                      pwm,
  output logic [7:0]                sw_period,
  output logic [7:0]                pwm_period,
  output scps_pkg::scps_opt_s       opt,
  output logic [15:0]               vref,
  output logic                      output_good_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic        strap_done;
    logic [7:0]  period;
    logic [3:0]  ph_index;
    logic [3:0]  ph_count;
    logic [7:0]  ph_delay;
    logic [3:0]  opt_code;
    logic [1:0]  sync_ff;
    logic [1:0]  en_ff;
    logic [1:0]  prev_ff;
    logic        sync_last;
    logic [15:0] loss_cnt;
    logic        locked;
    logic [7:0]  cnt;
    logic [7:0]  ph_cnt;
    logic        ph_run;
    logic        pwm;
    logic        sync_out;
    logic        sync_oe_n;
    logic        good;
    scps_pkg::scps_opt_s opt;
  } scps_top_s;

  scps_top_s s_q;
  scps_top_s s_d;

  scps_pkg::scps_opt_s opt_dec;
  logic [15:0]         ramp_vref;
  logic                ramping_up;
  logic                ramp_enable;
  logic                sync_rise;
  logic [7:0]          eff_period;
  logic [7:0]          half_period;

  // Strap frequency table, used at capture time
  function automatic logic [7:0] strap_period(input logic [1:0] code);
    unique case (code)
      scps_pkg::FSTRAP_28K7: strap_period = scps_pkg::PER_571K;
      scps_pkg::FSTRAP_31K6: strap_period = scps_pkg::PER_615K;
      scps_pkg::FSTRAP_34K8: strap_period = scps_pkg::PER_727K;
      scps_pkg::FSTRAP_38K3: strap_period = scps_pkg::PER_800K;
    endcase
  endfunction

  // Offset in clocks: period * index / count, count 0 meaning 16
  function automatic logic [7:0] phase_delay(input logic [7:0] per,
                                             input logic [3:0] idx,
                                             input logic [3:0] num);
    logic [12:0] prod;
    logic [4:0]  div;
    prod = 13'h0000;
    div  = 5'h00;
    div  = (num == 4'h0) ? 5'h10 : {1'b0, num};
    // Index at or above count wraps within the period
    prod = 13'({1'b0, per} * {9'h000, idx}) / 13'({8'h00, div});
    phase_delay = 8'(13'(prod % {5'h00, per}));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Option strap decode
  scps_opt_decode u_opt (
    .code (s_q.opt_code),
    .opt  (opt_dec)
  );

  assign eff_period  = two_phase ? {1'b0, s_q.period[7:1]} : s_q.period;
  assign half_period = {1'b0, eff_period[7:1]};
  assign sync_rise   = s_q.sync_ff[1] & ~s_q.sync_last;

  always_comb begin
    unique case (seq_mode)
      scps_pkg::SEQ_GROUP: ramp_enable = s_q.en_ff[1] & s_q.prev_ff[1];
      default:             ramp_enable = s_q.en_ff[1];
    endcase
  end

  scps_ramp u_ramp (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .enable     (ramp_enable),
    .target     (vout_target),
    .cfg        (ramp_cfg),
    .vref       (ramp_vref),
    .ramping_up (ramping_up)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers for pins
    s_d.sync_ff   = {s_q.sync_ff[0], sync_in};
    s_d.en_ff     = {s_q.en_ff[0], enable_pin};
    s_d.prev_ff   = {s_q.prev_ff[0], group_wire_bus_prev_good};
    s_d.sync_last = s_q.sync_ff[1];
    s_d.opt       = opt_dec;

    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.period     = strap_period(freq_strap_code);
      s_d.opt_code   = option_strap_resistor;
      s_d.ph_index   = bus_address[3:0];
      s_d.ph_count   = 4'h0;
    end else begin
      if (freq_cmd_wr && freq_cmd_period != 8'h00) begin
        s_d.period = freq_cmd_period;
      end
      if (phase_cmd_wr) begin
        s_d.ph_index = phase_cmd_index;
        s_d.ph_count = phase_cmd_count;
      end
    end
    s_d.ph_delay = phase_delay(eff_period, s_q.ph_index, s_q.ph_count);

    // Pin direction, output enable low drives
    s_d.sync_oe_n = ~sync_cfg.sync_out_en;

    // Loss timer: a follower without edges reverts to internal clock
    if (sync_rise) begin
      s_d.loss_cnt = 16'h0000;
    end else if (s_q.loss_cnt != 16'(scps_pkg::SYNC_LOSS_CYC)) begin
      s_d.loss_cnt = s_q.loss_cnt + 16'h0001;
    end
    // External clock only when configured as input follower
    if (!sync_cfg.use_ext_clk || sync_cfg.sync_out_en) begin
      s_d.locked = 1'b0;
    end else if (sync_rise) begin
      s_d.locked = 1'b1;
    end else if (s_q.loss_cnt == 16'(scps_pkg::SYNC_LOSS_CYC)) begin
      s_d.locked = 1'b0;
    end

    // Period counter, restarted by the sync edge when following
    if ((s_q.locked && sync_rise) || s_q.cnt + 8'h01 >= eff_period) begin
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
    // Source clock out: high in the first half of each period
    s_d.sync_out = sync_cfg.sync_out_en && (s_d.cnt < half_period);

    // PWM rise delayed from reference rise only when synced
    if (s_d.cnt == 8'h00) begin
      s_d.ph_cnt = 8'h00;
      s_d.ph_run = s_q.locked && (s_q.ph_delay != 8'h00);
    end else if (s_q.ph_run) begin
      s_d.ph_cnt = s_q.ph_cnt + 8'h01;
    end
    // Delay counted in clocks of one period fraction
    if (s_d.cnt == 8'h00 && !(s_q.locked && s_q.ph_delay != 8'h00)) begin
      s_d.pwm = ramp_vref != 16'h0000;
    end else if (s_q.ph_run && s_q.ph_cnt + 8'h01 == s_q.ph_delay) begin
      s_d.pwm    = ramp_vref != 16'h0000;
      s_d.ph_run = 1'b0;
    end else if (s_q.pwm && (s_q.ph_cnt >= half_period || s_d.cnt == half_period)) begin
      s_d.pwm = 1'b0;
    end

    // Good pin hysteresis, low during ramp-up
    if (ramping_up || ramp_vref == 16'h0000) begin
      s_d.good = 1'b0;
    end else if ({10'h000, ramp_vref} * 26'h400 >=
                 {16'h0000, scps_pkg::PG_ON_FRAC} * {10'h000, vout_target}) begin
      s_d.good = 1'b1;
    end else if ({10'h000, ramp_vref} * 26'h400 <
                 {16'h0000, scps_pkg::PG_OFF_FRAC} * {10'h000, vout_target}) begin
      s_d.good = 1'b0;
    end
  end

  // Register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.period    <= scps_pkg::PER_DEFAULT;
      s_q.sync_oe_n <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  assign pwm             = s_q.pwm;
  assign sync_out        = s_q.sync_out;
  assign sync_oe_n       = s_q.sync_oe_n;
  assign sw_period       = s_q.period;
  assign pwm_period      = s_q.cnt == 8'h00 ? s_q.period : s_q.period;
  assign opt             = s_q.opt;
  assign vref            = ramp_vref;
  assign output_good_pin = s_q.good;

endmodule // scps_top

/* File: scps_sync_src.sv */
// Far-side sync source: an outside oscillator on the shared sync line.
// Assumes the bench gates it with run; the line stands still while stopped.
`timescale 1ns/1ps
module scps_sync_src (
  input  wire logic run,
  output logic      sync
);
  // outside source feeds followers
  // Phase offset keeps its edges 12 ns after a system clock rise, away from the clock edges
  initial begin
    sync = 1'b0;
    #37;
    forever #200 if (run) sync = !sync;
  end
endmodule // scps_sync_src

/* File: scps_top_sva.sv */
// Port-level checker for the switching clock and soft-start block.
// Assumes it is bound to scps_top and sees only that module's ports.
`timescale 1ns/1ps
module scps_top_sva (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire logic                 freq_cmd_wr,
  input wire logic [7:0]           freq_cmd_period,
  input scps_pkg::scps_syncfg_s    sync_cfg,
  input scps_pkg::scps_ramp_s      ramp_cfg,
  input wire logic                 enable_pin,
  input wire logic                 sync_oe_n,
  input wire logic [7:0]           sw_period,
  input wire logic [15:0]          vref,
  input wire logic                 output_good_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Period register; strap capture edge is excluded
  a_reset_default: assert property (disable iff (1'b0)
    rst |=> sw_period == scps_pkg::PER_DEFAULT && sync_oe_n) else $error("bad reset period");
  a_freq_write: assert property (!$past(rst) && ce && freq_cmd_wr && freq_cmd_period != 8'h00
    |=> sw_period == $past(freq_cmd_period)) else $error("period write lost");
  a_freq_hold: assert property (!$past(rst) && !(ce && freq_cmd_wr && freq_cmd_period != 8'h00)
    |=> $stable(sw_period)) else $error("period moved without command");
  // Pin direction follows the held configuration
  a_oe_follow: assert property ((ce && $stable(sync_cfg.sync_out_en)) [*2]
    |-> sync_oe_n == !sync_cfg.sync_out_en) else $error("sync pin direction wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Good pin during ramp and at zero output
  a_good_ramp: assert property (vref > $past(vref) |-> !output_good_pin)
    else $error("good high while ramping");
  a_good_floor: assert property ((vref == 16'h0000) [*2] |-> !output_good_pin)
    else $error("good high with no output");
  // Immediate stop when soft-stop is off
  a_hard_stop: assert property ((ce && !enable_pin && !ramp_cfg.soft_stop_en) [*5]
    |-> vref == 16'h0000) else $error("output not stopped");
  // Equal steps while the reference moves up
  a_ramp_step: assert property (vref > $past(vref) && $past(vref) > $past(vref, 2)
    |-> vref - $past(vref) == $past(vref) - $past(vref, 2)) else $error("ramp not linear");
endmodule // scps_top_sva

bind scps_top scps_top_sva u_sva (.clk, .rst, .ce, .freq_cmd_wr, .freq_cmd_period, .sync_cfg,
  .ramp_cfg, .enable_pin, .sync_oe_n, .sw_period, .vref, .output_good_pin);

/* File: scps_top_bench.sv */
// Self-checking bench for the switching clock and soft-start block.
// Assumes scps_top, its checker and the sync source model are compiled first.
`timescale 1ns/1ps
module scps_top_bench;
  logic clk = 0, rst = 1, ce = 1, freq_cmd_wr = 0, two_phase = 0, phase_cmd_wr = 0;
  // One common enable, held high so pwm runs
  // Pulses only come while the reference is above zero, so output is on early
  logic enable_pin = 1, group_wire_bus_prev_good = 0, run = 0, ext;
  logic [1:0] freq_strap_code = 0, seq_mode = 0;
  logic [3:0] option_strap_resistor = 0, phase_cmd_index = 0, phase_cmd_count = 0;
  // Single module, no four-phase partner address
  logic [6:0] bus_address = 7'h24;
  logic [7:0] freq_cmd_period = 0, sw_period, pwm_period;
  logic [15:0] vout_target = 16'h0A00, vref;
  logic sync_in, sync_out, sync_oe_n, pwm, output_good_pin;
  scps_pkg::scps_syncfg_s sync_cfg = '0;
  scps_pkg::scps_ramp_s ramp_cfg = '0;
  scps_pkg::scps_opt_s opt;
  int miscompares = 0, cmp_count = 0, n, t0, v1, d0, d1, d2;
  int khz[4] = '{571, 615, 727, 800};
  // Strap table rows: page 0 limit, page 1 limit, topology and droop
  logic [15:0] tbl[11] = '{{6'h19, 6'h19, 4'h0}, {6'h23, 6'h23, 4'h0}, {6'h23, 6'h19, 4'h0},
    {6'h19, 6'h23, 4'h0}, {6'h19, 6'h19, 4'h4}, {6'h23, 6'h23, 4'h4}, {6'h23, 6'h23, 4'hA},
    {6'h23, 6'h23, 4'hE}, {6'h14, 6'h14, 4'h4}, {6'h14, 6'h14, 4'h0}, {6'h23, 6'h23, 4'h0}};
  // Shared line: the device wins while its enable is low
  assign sync_in = sync_oe_n ? ext : sync_out;
  always #25 clk = !clk;
  scps_sync_src u_src (.run(run), .sync(ext));
  scps_top uut (.clk, .rst, .ce, .freq_strap_code, .option_strap_resistor, .bus_address,
    .freq_cmd_wr, .freq_cmd_period, .two_phase, .sync_cfg, .phase_cmd_wr, .phase_cmd_index,
    .phase_cmd_count, .ramp_cfg, .vout_target, .enable_pin, .seq_mode,
    .group_wire_bus_prev_good, .sync_in, .sync_out, .sync_oe_n, .pwm, .sw_period,
    .pwm_period, .opt, .vref, .output_good_pin);
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Straps are only seen on the first edge out of reset
  task do_reset(input logic [1:0] fc, input logic [3:0] oc);
    @(posedge clk);
    rst <= 1;
    freq_strap_code <= fc;
    option_strap_resistor <= oc;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Host side: one phase or period command write, then 100 cycles to settle
  task pulse(input bit ph, input logic [7:0] v);
    @(posedge clk);
    if (ph) {phase_cmd_wr, phase_cmd_index, phase_cmd_count} <= {1'b1, v};
    else {freq_cmd_wr, freq_cmd_period} <= {1'b1, v};
    @(posedge clk);
    {phase_cmd_wr, freq_cmd_wr} <= 2'b00;
    repeat (100) @(posedge clk);
  endtask
  // Cycles until the next rise of the sync line or of the pulse
  task rise(input bit w, output int k);
    k = 0;
    do begin @(posedge clk); k++; end while ((w ? sync_in : pwm) !== 1'b0);
    do begin @(posedge clk); k++; end while ((w ? sync_in : pwm) !== 1'b1);
  endtask
  // Ramp timing: start delay, first step value and length to the end value
  task span(input logic [15:0] e, output int ts, output int fv, output int k);
    logic [15:0] s;
    s = vref;
    ts = 0;
    k = 0;
    do begin @(posedge clk); ts++; end while (vref === s);
    fv = vref;
    while (vref !== e) begin @(posedge clk); k++; end
  endtask
  task phase(output int d);
    repeat (50) @(posedge clk);
    rise(1, n);
    rise(0, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      do_reset(2'(i % 4), 4'(i));
      check(opt, tbl[i]);
      check(sw_period, 20000000 / (khz[i % 4] * 1000));
      rise(0, n);
      rise(0, n);
      check(n, 20000000 / (khz[i % 4] * 1000));
    end
    run <= 1;
    pulse(0, 8'h1E);
    pulse(0, 8'h00);
    check(sw_period, 8'h1E);
    rise(0, n);
    rise(0, n);
    check(n, 30);
    // Match the period to the outside source so the follower period agrees
    pulse(0, 8'h08);
    sync_cfg <= '{1'b0, 1'b1};
    phase(d1);
    rise(0, n);
    check(n, 8);
    pulse(1, 8'h04);
    phase(d0);
    pulse(1, 8'h24);
    phase(d2);
    check((d1 + 8 - d0) % 8, 2);
    check((d2 + 8 - d0) % 8, 4);
    sync_cfg <= '{1'b1, 1'b0};
    rise(1, n);
    rise(1, n);
    check(n, 8);
    sync_cfg <= '0;
    // Event chaining is outside; drop enable before the ramp tests
    enable_pin <= 0;
    repeat (6) @(posedge clk);
    ramp_cfg <= '{16'h000A, 16'h0014, 16'h0008, 16'h0010, 1'b0};
    enable_pin <= 1;
    span(16'h0A00, t0, v1, n);
    check(t0 > 10, 1);
    check({v1, n}, {32'h80, 32'd19});
    repeat (4) @(posedge clk);
    check(output_good_pin, 1);
    enable_pin <= 0;
    repeat (6) @(posedge clk);
    check({vref, output_good_pin}, 17'h0);
    ramp_cfg <= '{16'h000A, 16'h0014, 16'h0008, 16'h0010, 1'b1};
    enable_pin <= 1;
    span(16'h0A00, t0, v1, n);
    enable_pin <= 0;
    span(16'h0000, t0, v1, n);
    check(t0 > 8, 1);
    check({v1, n}, {32'h960, 32'd15});
    seq_mode <= scps_pkg::SEQ_GROUP;
    enable_pin <= 1;
    repeat (60) @(posedge clk);
    check(vref, 0);
    group_wire_bus_prev_good <= 1;
    span(16'h0A00, t0, v1, n);
    check(v1, 16'h0080);
    wrap_up;
  end
endmodule // scps_top_bench
